// >>> hw/fiepb_bank.sv
// Functional notes
// - Pending view is raw status ANDed with enable, word 2 bit 31 unmasked; pending except word 2 bit 31 ORs onto core line.
// - Pending word 2 bit 25 is OR of pending sources 32 to 63.
// - Pending word 2 bit 24 is OR of pending sources 0 to 31.
// - Pending word 2 bit 31 shows the processor complex interrupt level.
// - Bits 15:8 are software triggers, cleared only via the trigger clear register.
// - Bus-error bit 7 sets on bus error, holds until complex reset.
// - Bit 6 sets on a burst access longer than zero into video peripheral space.
// - Bit 5 is vector core 1 halt; bit 4 core 0, or core 1 if config bit 10.
// - Doorbell bits 3 and 2 clear when their doorbell register is read.
// - Timer bit 0 clears on interrupt control write; bit 1 is mailbox 0.
// - Writing one to a set-enable bit enables it; zeros change nothing.
// - Writing one to a clear-enable bit disables it; zeros change nothing.
// - Reading set-enable or clear-enable returns the current enable mask.
// - Enable word 1 covers sources 32 to 63 and resets to zero.
// - Enable word 0 covers sources 0 to 31 and resets to zero.
// - Writing one to trigger set register sets that bit; reads return bits.
// - Raw status shows sources unmasked; pending derived from raw by the mask.
//
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module fiepb_bank
	import fiepb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [63:0] periph_irq_i,
	input wire logic cpu_irq_i,
	input wire logic cpx_reset_i,
	input wire logic bus_error_i,
	input wire logic burst_video_i,
	input wire logic [3:0] burst_len_i,
	input wire logic vec_core0_halt_i,
	input wire logic vec_core1_halt_i,
	input wire logic doorbell0_event_i,
	input wire logic doorbell1_event_i,
	input wire logic mailbox0_irq_i,
	input wire logic timer_event_i,
	output logic [NUM_CORES-1:0] fast_interrupt_o
);
	// ==========================================
	// Decode helpers
	function automatic logic [31:0] byte_mask(input logic [3:0] sel);
		byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : byte_mask

	function automatic logic is_core(input logic [ADR_W-1:0] adr);
		is_core = (adr[ADR_W-1:ADR_W-4] == CORE_REGION);
	endfunction : is_core

	// ==========================================
	// Wishbone slave handshake
	logic ack;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic req;
	logic wr_go;
	logic rd_go;
	logic [31:0] wmask;
	logic [31:0] wdata;
	logic [1:0] core_idx;
	logic [5:0] core_off;

	assign req = wb_cyc_i & wb_stb_i;
	assign wr_go = req & ack & wb_we_i;
	assign rd_go = req & ack & ~wb_we_i;
	assign wmask = byte_mask(wb_sel_i);
	assign wdata = wb_dat_i & wmask;
	assign core_idx = wb_adr_i[CORE_SEL_LSB+1:CORE_SEL_LSB];
	assign core_off = wb_adr_i[CORE_SEL_LSB-1:0];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack <= 1'b0;
		else
			ack <= req & ~ack;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata <= WORD_ZERO;
		else if (req & ~ack)
			rdata <= next_rdata;
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdata;

	// ==========================================
	// Peripheral source synchroniser
	logic [63:0] periph_meta;
	logic [63:0] periph_sync;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			periph_meta <= 64'h0000_0000_0000_0000;
			periph_sync <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			periph_meta <= periph_irq_i;
			periph_sync <= periph_meta;
		end
	end

	// ==========================================
	// Configuration register
	logic [31:0] config_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			config_reg <= CFG_RESET;
		else if (wr_go && wb_adr_i == ADR_CONFIG)
			config_reg <= (config_reg & ~wmask) | (wdata & CFG_MASK);
	end

	// ==========================================
	// Software trigger bits
	logic [7:0] sw_bits;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sw_bits <= SW_RESET;
		else if (wr_go && wb_adr_i == ADR_SW_SET)
			sw_bits <= sw_bits | wdata[7:0];
		else if (wr_go && wb_adr_i == ADR_SW_CLEAR)
			sw_bits <= sw_bits & ~wdata[7:0];
	end

	// ==========================================
	// Local event flags
	logic timer_flag;
	logic door0_flag;
	logic door1_flag;
	logic bus_err_flag;
	logic addr_err_flag;
	logic halt_any;
	logic addr_err_hit;

	assign addr_err_hit = burst_video_i && (burst_len_i != 4'h0);
	assign halt_any = vec_core0_halt_i
		| (config_reg[CFG_HALT_COMBINE] & vec_core1_halt_i);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			timer_flag <= 1'b0;
		else if (timer_event_i)
			timer_flag <= 1'b1;
		else if (wr_go && wb_adr_i == ADR_INT_CTRL)
			timer_flag <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			door0_flag <= 1'b0;
		else if (doorbell0_event_i)
			door0_flag <= 1'b1;
		else if (rd_go && wb_adr_i == ADR_DOORBELL0)
			door0_flag <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			door1_flag <= 1'b0;
		else if (doorbell1_event_i)
			door1_flag <= 1'b1;
		else if (rd_go && wb_adr_i == ADR_DOORBELL1)
			door1_flag <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bus_err_flag <= 1'b0;
		else if (bus_error_i)
			bus_err_flag <= 1'b1;
		else if (cpx_reset_i)
			bus_err_flag <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			addr_err_flag <= 1'b0;
		else if (addr_err_hit)
			addr_err_flag <= 1'b1;
		else if (wr_go && wb_adr_i == ADR_RAW2 && wdata[BIT_ADDR_ERR])
			addr_err_flag <= 1'b0;
	end

	// ==========================================
	// Raw status words
	logic [NUM_WORDS-1:0][31:0] raw;

	assign raw[0] = periph_sync[31:0];
	assign raw[1] = periph_sync[63:32];
	assign raw[2] = {cpu_irq_i, 15'h0000, sw_bits, bus_err_flag,
		addr_err_flag, vec_core1_halt_i, halt_any, door1_flag, door0_flag,
		mailbox0_irq_i, timer_flag};

	// ==========================================
	// Per-core slices
	logic [NUM_CORES-1:0][NUM_WORDS-1:0][31:0] core_en;
	logic [NUM_CORES-1:0][NUM_WORDS-1:0][31:0] core_pend;
	logic [NUM_CORES-1:0] core_fiq;

	genvar c;
	genvar w;
	generate
		for (c = 0; c < NUM_CORES; c++)
		begin : g_core
			fiepb_slice_if sif ();
			for (w = 0; w < NUM_WORDS; w++)
			begin : g_stb
				assign sif.set_stb[w] = wr_go && is_core(wb_adr_i)
					&& core_idx == 2'(c)
					&& core_off == OFF_SET_EN0 + 6'(w) * OFF_WORD_STEP;
				assign sif.clr_stb[w] = wr_go && is_core(wb_adr_i)
					&& core_idx == 2'(c)
					&& core_off == OFF_CLR_EN0 + 6'(w) * OFF_WORD_STEP;
			end
			assign sif.wdata = wdata;
			assign sif.raw = raw;
			assign core_en[c] = sif.enable;
			assign core_pend[c] = sif.pending;
			assign core_fiq[c] = sif.fast_interrupt;
			fiepb_core_slice u_slice (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.sif(sif.slice)
			);
		end
	endgenerate

	assign fast_interrupt_o = core_fiq;

	// ==========================================
	// Read multiplexer
	always_comb
	begin
		next_rdata = WORD_ZERO;
		if (is_core(wb_adr_i))
		begin
			for (int i = 0; i < NUM_WORDS; i++)
			begin
				if (core_off == OFF_PEND0 + 6'(i) * OFF_WORD_STEP)
					next_rdata = core_pend[core_idx][i];
				if (core_off == OFF_SET_EN0 + 6'(i) * OFF_WORD_STEP
					|| core_off == OFF_CLR_EN0 + 6'(i) * OFF_WORD_STEP)
					next_rdata = core_en[core_idx][i];
			end
		end
		else
		begin
			unique case (wb_adr_i)
				ADR_RAW0: next_rdata = raw[0];
				ADR_RAW1: next_rdata = raw[1];
				ADR_RAW2: next_rdata = raw[2];
				ADR_SW_SET: next_rdata = {24'h00_0000, sw_bits};
				ADR_SW_CLEAR: next_rdata = {24'h00_0000, sw_bits};
				ADR_DOORBELL0: next_rdata = {31'h0000_0000, door0_flag};
				ADR_DOORBELL1: next_rdata = {31'h0000_0000, door1_flag};
				ADR_CONFIG: next_rdata = config_reg;
				default: next_rdata = WORD_ZERO;
			endcase
		end
	end

	// ==========================================
	// Checks
	chk_bus_err_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_err_flag && !cpx_reset_i) |=> bus_err_flag)
		else $error("bus error flag dropped without complex reset");
	chk_addr_err_set: assert property (@(posedge clk_i) disable iff (rst_i)
		addr_err_hit |=> raw[2][BIT_ADDR_ERR])
		else $error("address range error not flagged");
	chk_halt_combine: assert property (@(posedge clk_i) disable iff (rst_i)
		raw[2][BIT_HALT_ANY] == (vec_core0_halt_i
		|| (config_reg[CFG_HALT_COMBINE] && vec_core1_halt_i)))
		else $error("combined halt bit wrong");
	chk_door_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_go && wb_adr_i == ADR_DOORBELL0 && !doorbell0_event_i)
		|=> !door0_flag)
		else $error("doorbell read did not clear");
	chk_timer_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_go && wb_adr_i == ADR_INT_CTRL && !timer_event_i) |=> !timer_flag)
		else $error("timer flag not cleared by control write");
	chk_sw_set: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_go && wb_adr_i == ADR_SW_SET)
		|=> sw_bits == ($past(sw_bits) | $past(wdata[7:0])))
		else $error("software trigger set wrong");
	chk_sw_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wr_go && wb_adr_i == ADR_SW_CLEAR) |=> (sw_bits & $past(sw_bits))
		== $past(sw_bits))
		else $error("software trigger dropped without clear write");
	chk_cpu_irq_bit: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> core_pend[0][2][BIT_CPU_IRQ] == $past(cpu_irq_i))
		else $error("bit 31 does not follow interrupt input");
	chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
endmodule : fiepb_bank
`default_nettype wire

// >>> hw/fiepb_core_slice.sv
`timescale 1ns/1ps
`default_nettype none
module fiepb_core_slice
	import fiepb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	fiepb_slice_if.slice sif
);
	// ==========================================
	// Enable masks
	function automatic logic [31:0] word_mask(input int w);
		word_mask = (w == NUM_WORDS - 1) ? EN2_MASK : ~WORD_ZERO;
	endfunction : word_mask

	logic [NUM_WORDS-1:0][31:0] enable;
	logic [NUM_WORDS-1:0][31:0] pending;
	logic fast_interrupt;

	genvar w;
	generate
		for (w = 0; w < NUM_WORDS; w++)
		begin : g_word
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					enable[w] <= EN_RESET;
				else if (sif.set_stb[w])
					enable[w] <= enable[w] | (sif.wdata & word_mask(w));
				else if (sif.clr_stb[w])
					enable[w] <= enable[w] & ~(sif.wdata & word_mask(w));
			end
		end
	endgenerate

	// ==========================================
	// Pending views and fast-interrupt line
	logic [31:0] next_p0;
	logic [31:0] next_p1;
	assign next_p0 = sif.raw[0] & enable[0];
	assign next_p1 = sif.raw[1] & enable[1];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pending <= '0;
		end
		else
		begin
			pending[0] <= next_p0;
			pending[1] <= next_p1;
			pending[2] <= {sif.raw[2][BIT_CPU_IRQ], 5'h00, |next_p1, |next_p0,
				8'h00, sif.raw[2][15:0] & enable[2][15:0]};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fast_interrupt <= 1'b0;
		else
			fast_interrupt <= (|pending[0]) | (|pending[1]) | (|pending[2][15:0]);
	end

	assign sif.enable = enable;
	assign sif.pending = pending;
	assign sif.fast_interrupt = fast_interrupt;

	// ==========================================
	// Checks
	chk_pend_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> pending[1] == $past(sif.raw[1] & enable[1]))
		else $error("pending word 1 not raw and enable");
	chk_upper_sum: assert property (@(posedge clk_i) disable iff (rst_i)
		pending[2][BIT_UPPER_SUM] == (|pending[1]))
		else $error("upper summary bit mismatch");
	chk_lower_sum: assert property (@(posedge clk_i) disable iff (rst_i)
		pending[2][BIT_LOWER_SUM] == (|pending[0]))
		else $error("lower summary bit mismatch");
	chk_set_enable: assert property (@(posedge clk_i) disable iff (rst_i)
		sif.set_stb[1] |=> enable[1] == ($past(enable[1]) | $past(sif.wdata)))
		else $error("set-enable write wrong");
	chk_clr_enable: assert property (@(posedge clk_i) disable iff (rst_i)
		(sif.clr_stb[0] && !sif.set_stb[0])
		|=> enable[0] == ($past(enable[0]) & ~$past(sif.wdata)))
		else $error("clear-enable write wrong");
	chk_en_reset: assert property (@(posedge clk_i)
		!rst_i && $past(rst_i) |-> enable[0] == EN_RESET
		&& enable[1] == EN_RESET)
		else $error("enables not zero after reset");
	chk_fiq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> fast_interrupt == ((|$past(pending[0])) | (|$past(pending[1]))
		| (|$past(pending[2][15:0]))))
		else $error("fast interrupt level wrong");
endmodule : fiepb_core_slice
`default_nettype wire

// >>> inc/fiepb_pkg.sv
`default_nettype none
package fiepb_pkg;
	// ==========================================
	// Sizes
	localparam int NUM_CORES = 4;
	localparam int NUM_WORDS = 3;
	localparam int ADR_W = 12;
	localparam int CORE_SEL_LSB = 6;
	// ==========================================
	// Global register byte addresses
	localparam logic [11:0] ADR_RAW0 = 12'h000;
	localparam logic [11:0] ADR_RAW1 = 12'h004;
	localparam logic [11:0] ADR_RAW2 = 12'h008;
	localparam logic [11:0] ADR_SW_SET = 12'h00C;
	localparam logic [11:0] ADR_SW_CLEAR = 12'h010;
	localparam logic [11:0] ADR_INT_CTRL = 12'h014;
	localparam logic [11:0] ADR_DOORBELL0 = 12'h018;
	localparam logic [11:0] ADR_DOORBELL1 = 12'h01C;
	localparam logic [11:0] ADR_CONFIG = 12'h020;
	// ==========================================
	// Per-core block: base plus core index times 0x40
	localparam logic [3:0] CORE_REGION = 4'h1;
	localparam logic [5:0] OFF_PEND0 = 6'h00;
	localparam logic [5:0] OFF_SET_EN0 = 6'h10;
	localparam logic [5:0] OFF_CLR_EN0 = 6'h20;
	localparam logic [5:0] OFF_WORD_STEP = 6'h04;
	// ==========================================
	// Bit positions of the third word and of the config register
	localparam int BIT_CPU_IRQ = 31;
	localparam int BIT_UPPER_SUM = 25;
	localparam int BIT_LOWER_SUM = 24;
	localparam int SW_LSB = 8;
	localparam int BIT_BUS_ERR = 7;
	localparam int BIT_ADDR_ERR = 6;
	localparam int BIT_HALT1 = 5;
	localparam int BIT_HALT_ANY = 4;
	localparam int BIT_DOOR1 = 3;
	localparam int BIT_DOOR0 = 2;
	localparam int BIT_MAILBOX = 1;
	localparam int BIT_TIMER = 0;
	localparam int CFG_HALT_COMBINE = 10;
	// ==========================================
	// Reset values and masks
	localparam logic [31:0] EN_RESET = 32'h0000_0000;
	localparam logic [31:0] EN2_MASK = 32'h0000_FFFF;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [7:0] SW_RESET = 8'h00;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_MASK = 32'h0000_0400;
	typedef logic [31:0] fiepb_word_type;
endpackage : fiepb_pkg
`default_nettype wire

// >>> inc/fiepb_slice_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fiepb_slice_if;
	import fiepb_pkg::*;
	logic [NUM_WORDS-1:0] set_stb;
	logic [NUM_WORDS-1:0] clr_stb;
	fiepb_word_type wdata;
	logic [NUM_WORDS-1:0][31:0] raw;
	logic [NUM_WORDS-1:0][31:0] enable;
	logic [NUM_WORDS-1:0][31:0] pending;
	logic fast_interrupt;
	modport bank (output set_stb, output clr_stb, output wdata, output raw,
		input enable, input pending, input fast_interrupt);
	modport slice (input set_stb, input clr_stb, input wdata, input raw,
		output enable, output pending, output fast_interrupt);
endinterface : fiepb_slice_if
`default_nettype wire

// >>> tb/fast_irq_enable_pending_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fast_irq_enable_pending_bank_bench;
	import fiepb_pkg::*;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	localparam logic [31:0] LOW8 = 32'h0000_00FF;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [11:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wdat = '0, rdat, r, m, e0;
	logic ack;
	logic [3:0] fi;
	logic [63:0] lvl = '0, p, s_irq;
	logic [3:0] misc = '0, s_misc, len = '0, s_len;
	logic [5:0] ev = '0, s_ev;
	logic [31:0] rnd = 32'h437d_62a9;
	logic [31:0] exp_q[$], msk_q[$];
	int bad_count = 0, n_tests = 0, cycles = 0;
	always #12.5 clk_i = ~clk_i;
	// ==========================================
	// Design and source model
	fiepb_src_model src (.clk_i(clk_i), .rst_i(rst_i), .lvl_i(lvl),
		.misc_i(misc), .ev_i(ev), .len_i(len), .periph_irq_o(s_irq),
		.misc_o(s_misc), .ev_o(s_ev), .len_o(s_len));
	fiepb_bank dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.periph_irq_i(s_irq), .cpu_irq_i(s_misc[0]),
		.cpx_reset_i(s_ev[4]), .bus_error_i(s_ev[3]),
		.burst_video_i(s_ev[5]), .burst_len_i(s_len),
		.vec_core0_halt_i(s_misc[1]), .vec_core1_halt_i(s_misc[2]),
		.doorbell0_event_i(s_ev[1]), .doorbell1_event_i(s_ev[2]),
		.mailbox0_irq_i(s_misc[3]), .timer_event_i(s_ev[0]),
		.fast_interrupt_o(fi));
	// ==========================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	function automatic logic [11:0] ca(input int c, input logic [5:0] o);
		return 12'h100 + 12'(c) * 12'h040 + {6'h00, o};
	endfunction : ca
	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		n_tests++;
		if (seen !== expd)
		begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask : check
	task automatic print_verdict();
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 100);
		if (ack !== 1'b1)
		begin
			bad_count++;
			print_verdict();
		end
		else
		begin
			cyc <= 1'b0;
			stb <= 1'b0;
			we <= 1'b0;
		end
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] k);
		exp_q.push_back(e);
		msk_q.push_back(k);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic pulse(input int k);
		@(posedge clk_i);
		ev[k] <= 1'b1;
		@(posedge clk_i);
		ev[k] <= 1'b0;
		idle(3);
	endtask : pulse
	function automatic logic [31:0] next_rnd();
		rnd = lfsr(rnd);
		return rnd;
	endfunction : next_rnd
	// ==========================================
	// Read result checker
	always @(posedge clk_i)
	begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
		begin
			check(rdat & msk_q[0], exp_q[0]);
			exp_q.pop_front();
			msk_q.pop_front();
		end
	end
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			print_verdict();
		end
	end
	// ==========================================
	// Scenarios
	initial
	begin
		idle(16);
		rst_i <= 1'b0;
		for (int c = 0; c < NUM_CORES; c++)
		begin
			rd(ca(c, OFF_SET_EN0), EN_RESET, ALL);
			rd(ca(c, OFF_SET_EN0 + 6'h04), EN_RESET, ALL);
			rd(ca(c, OFF_CLR_EN0), EN_RESET, ALL);
			rd(ca(c, OFF_PEND0 + 6'h08), WORD_ZERO, ALL);
		end
		r = next_rnd();
		m = next_rnd();
		e0 = r & ~m;
		wr(ca(0, OFF_SET_EN0), r);
		wr(ca(0, OFF_SET_EN0), 32'h0000_0000);
		rd(ca(0, OFF_SET_EN0), r, ALL);
		wr(ca(0, OFF_CLR_EN0), m);
		rd(ca(0, OFF_CLR_EN0), e0, ALL);
		rd(ca(0, OFF_SET_EN0), e0, ALL);
		rd(ca(1, OFF_SET_EN0), EN_RESET, ALL);
		p = {next_rnd(), next_rnd()};
		lvl <= p;
		wr(ca(1, OFF_SET_EN0 + 6'h04), ALL);
		idle(6);
		rd(ADR_RAW1, p[63:32], ALL);
		rd(ca(0, OFF_PEND0), p[31:0] & e0, ALL);
		rd(ca(1, OFF_PEND0 + 6'h04), p[63:32], ALL);
		rd(ca(0, OFF_PEND0 + 6'h08), {7'h00, |(p[31:0] & e0), 24'h0}, ALL);
		rd(ca(1, OFF_PEND0 + 6'h08), {6'h00, |p[63:32], 25'h0}, ALL);
		check({28'h0, fi}, {30'h0, |p[63:32], |(p[31:0] & e0)});
		lvl <= '0;
		misc <= 4'b0001;
		idle(6);
		rd(ca(3, OFF_PEND0 + 6'h08), 32'h8000_0000, ALL);
		check({31'h0, fi[3]}, 32'h0000_0000);
		misc <= 4'b0000;
		wr(ca(2, OFF_SET_EN0 + 6'h08), ALL);
		rd(ca(2, OFF_SET_EN0 + 6'h08), EN2_MASK, 32'h7FFF_FFFF);
		wr(ADR_SW_SET, 32'h0000_00A5);
		rd(ADR_SW_SET, 32'h0000_00A5, LOW8);
		idle(3);
		rd(ca(2, OFF_PEND0 + 6'h08), 32'h0000_A500, ALL);
		check({31'h0, fi[2]}, 32'h0000_0001);
		wr(ADR_SW_CLEAR, 32'h0000_0005);
		idle(3);
		rd(ca(2, OFF_PEND0 + 6'h08), 32'h0000_A000, ALL);
		wr(ADR_SW_CLEAR, LOW8);
		idle(3);
		check({31'h0, fi[2]}, 32'h0000_0000);
		pulse(0);
		rd(ADR_RAW2, 32'h0000_0001, LOW8);
		wr(ADR_INT_CTRL, 32'h0000_0000);
		rd(ADR_RAW2, 32'h0000_0000, LOW8);
		pulse(1);
		rd(ADR_DOORBELL0, 32'h0000_0001, 32'h0000_0001);
		rd(ADR_RAW2, 32'h0000_0000, LOW8);
		pulse(2);
		rd(ADR_RAW2, 32'h0000_0008, LOW8);
		rd(ADR_DOORBELL1, 32'h0000_0001, 32'h0000_0001);
		rd(ADR_RAW2, 32'h0000_0000, LOW8);
		pulse(3);
		wr(ADR_INT_CTRL, 32'h0000_0000);
		rd(ADR_RAW2, 32'h0000_0080, LOW8);
		pulse(4);
		rd(ADR_RAW2, 32'h0000_0000, LOW8);
		pulse(5);
		rd(ADR_RAW2, 32'h0000_0000, LOW8);
		len <= 4'h3;
		pulse(5);
		rd(ADR_RAW2, 32'h0000_0040, LOW8);
		wr(ADR_RAW2, 32'h0000_0040);
		misc <= 4'b1100;
		idle(4);
		rd(ADR_RAW2, 32'h0000_0022, LOW8);
		wr(ADR_CONFIG, CFG_MASK);
		rd(ADR_RAW2, 32'h0000_0032, LOW8);
		misc <= 4'b0010;
		wr(ADR_CONFIG, CFG_RESET);
		idle(3);
		rd(ADR_RAW2, 32'h0000_0010, LOW8);
		rd(12'h3FC, WORD_ZERO, ALL);
		wr(12'h3FC, ALL);
		rd(ca(0, OFF_SET_EN0), e0, ALL);
		idle(2);
		print_verdict();
	end
endmodule : fast_irq_enable_pending_bank_bench
`default_nettype wire

// >>> tb/fiepb_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Peripheral and processor-side source logic
module fiepb_src_model
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [63:0] lvl_i,
	input wire logic [3:0] misc_i,
	input wire logic [5:0] ev_i,
	input wire logic [3:0] len_i,
	output logic [63:0] periph_irq_o,
	output logic [3:0] misc_o,
	output logic [5:0] ev_o,
	output logic [3:0] len_o
);
	// Levels follow the request one edge later; events are one-cycle pulses
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			periph_irq_o <= '0;
			misc_o <= '0;
			ev_o <= '0;
			len_o <= '0;
		end
		else
		begin
			periph_irq_o <= lvl_i;
			misc_o <= misc_i;
			ev_o <= ev_i;
			len_o <= len_i;
		end
	end
endmodule : fiepb_src_model
`default_nettype wire
